// >>> alu_branch_exec.sv
// Purpose: Execution datapath for arithmetic, logic and flow instructions.
// Assumes: Operands are valid with op_valid; register file applies writes.
// Notes:   Operands are captured at issue and held for multi-cycle ops.
`default_nettype none

// Overview of operation
// - Add registers, optional carry, one cycle
// - Word add immediate, two cycles, ZCNVS
// - Subtract register or immediate, one cycle
// - Subtract with carry also removes carry
// - Word subtract immediate, two cycles, ZCNVS
// - Logic ops update only Z, N, V
// - Bit clear ands with ones minus mask
// - Bit set ors mask into destination
// - Test ands self, clear xors self
// - Multiplies write product pair, two cycles
// - Fractional multiplies shift product left once
// - Relative call pushes return, three cycles
// - Indirect jump loads pointer, two cycles
// - Indirect call pushes, loads pointer, three cycles
// - Compare skip equal, one to three cycles
// - Compares set flags, store nothing
module alu_branch_exec (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          rst_n,
  // Instruction request
  input  wire logic          op_valid,
  input  wire alu_pkg::op_t  op_code,
  input  wire logic          large_memory,
  input  wire logic          skip_long,
  // Operands
  input  wire logic [7:0]    rd_in,
  input  wire logic [7:0]    rr_in,
  input  wire logic [7:0]    imm,
  input  wire logic [15:0]   pair_in,
  input  wire logic [15:0]   pc_in,
  input  wire logic [11:0]   offset,
  input  wire logic [15:0]   z_in,
  input  wire logic [15:0]   abs_addr,
  input  wire logic [15:0]   pop_data,
  // Completion
  output logic               ready,
  output logic               done,
  // Register file writes
  output logic               rd_we,
  output logic      [7:0]    rd_data,
  output logic               pair_we,
  output logic      [15:0]   pair_data,
  output logic               prod_we,
  output logic      [15:0]   prod_data,
  // Program counter and stack
  output logic               pc_load,
  output logic      [15:0]   pc_value,
  output logic               push_we,
  output logic      [15:0]   push_data,
  // Status
  output logic      [7:0]    sreg
);

  alu_pkg::state_t state;
  alu_pkg::op_t    h_op;
  alu_pkg::op_t    c_op;
  logic [2:0]  remain;
  logic [7:0]  h_rd, h_rr, h_imm;
  logic [15:0] h_pair, h_pc, h_z, h_abs, h_pop;
  logic [11:0] h_off;
  logic        h_long, h_large;
  logic [7:0]  c_rd, c_rr, c_imm;
  logic [15:0] c_pair, c_pc, c_z, c_abs, c_pop;
  logic [11:0] c_off;
  logic        c_long, c_large;
  logic        busy, accept, fire;
  logic        use_imm, is_sub, use_c, chain_z, self_op;
  logic        inc_dec, is_or, is_xor, twos, mul_as, mul_bs, mul_fr;
  logic [7:0]  ax, ay, ar, lr, mul_zero;
  logic [8:0]  sum9;
  logic [4:0]  sum5;
  logic        ar_c, ar_h, ar_v, ar_z;
  logic [16:0] wsum;
  logic [15:0] wr, mprod, rel_tgt;
  logic        wc, wv, mc;
  logic [7:0]  f_arith, f_logic, f_word, f_mul, f_compl;
  logic        next_rd_we, next_pair_we, next_prod_we;
  logic        next_pc_load, next_push_we;
  logic [7:0]  next_rd_data, mask, fv, next_sreg;
  logic [15:0] next_pc_value, next_push_data;
  logic [2:0]  cyc;

  // Live operands at issue, captured copies while waiting
  assign busy    = (state == alu_pkg::st_busy);
  assign accept  = op_valid && ready;
  assign c_op    = busy ? h_op    : op_code;
  assign c_rd    = busy ? h_rd    : rd_in;
  assign c_rr    = busy ? h_rr    : rr_in;
  assign c_imm   = busy ? h_imm   : imm;
  assign c_pair  = busy ? h_pair  : pair_in;
  assign c_pc    = busy ? h_pc    : pc_in;
  assign c_off   = busy ? h_off   : offset;
  assign c_z     = busy ? h_z     : z_in;
  assign c_abs   = busy ? h_abs   : abs_addr;
  assign c_pop   = busy ? h_pop   : pop_data;
  assign c_long  = busy ? h_long  : skip_long;
  assign c_large = busy ? h_large : large_memory;

  // Operand class decode
  assign use_imm = c_op inside {alu_pkg::op_sub_imm, alu_pkg::op_and_imm,
    alu_pkg::op_sub_imm_carry, alu_pkg::op_compare_immediate,
    alu_pkg::op_or_imm, alu_pkg::op_set_bits_mask};
  assign is_sub  = c_op inside {alu_pkg::op_sub_reg, alu_pkg::op_sub_imm,
    alu_pkg::op_sub_reg_carry, alu_pkg::op_sub_imm_carry,
    alu_pkg::op_compare, alu_pkg::op_compare_with_carry,
    alu_pkg::op_compare_immediate, alu_pkg::op_twos_complement,
    alu_pkg::op_decrement, alu_pkg::op_sub_imm_word};
  assign chain_z = c_op inside {alu_pkg::op_sub_reg_carry,
    alu_pkg::op_sub_imm_carry, alu_pkg::op_compare_with_carry};
  assign use_c   = chain_z || (c_op == alu_pkg::op_add_carry);
  assign self_op = c_op inside {alu_pkg::op_test_zero_minus,
    alu_pkg::op_zero_register, alu_pkg::op_twos_complement};
  assign inc_dec = c_op inside {alu_pkg::op_increment, alu_pkg::op_decrement};
  assign is_or   = c_op inside {alu_pkg::op_or_reg, alu_pkg::op_or_imm,
    alu_pkg::op_set_bits_mask};
  assign is_xor  = c_op inside {alu_pkg::op_xor_reg, alu_pkg::op_zero_register};
  assign twos    = (c_op == alu_pkg::op_twos_complement);

  // Operand selection for the byte adder and logic unit
  assign ax = twos ? alu_pkg::BYTE_ZERO : c_rd;
  assign ay = self_op ? c_rd :
              inc_dec ? alu_pkg::BYTE_ONE :
              (c_op == alu_pkg::op_clear_bits_mask) ?
                alu_pkg::BYTE_ONES - c_imm :
              use_imm ? c_imm : c_rr;

  // Byte adder; bit 8 and bit 4 give carry or borrow
  assign sum9 = is_sub ?
    {1'b0, ax} - {1'b0, ay} - {8'h00, use_c & sreg[alu_pkg::FLAG_C]} :
    {1'b0, ax} + {1'b0, ay} + {8'h00, use_c & sreg[alu_pkg::FLAG_C]};
  assign sum5 = is_sub ?
    {1'b0, ax[3:0]} - {1'b0, ay[3:0]} - {4'h0, use_c & sreg[alu_pkg::FLAG_C]} :
    {1'b0, ax[3:0]} + {1'b0, ay[3:0]} + {4'h0, use_c & sreg[alu_pkg::FLAG_C]};
  assign ar   = sum9[7:0];
  assign ar_c = sum9[8];
  assign ar_h = sum5[4];
  assign ar_v = is_sub ? (ax[7] & ~ay[7] & ~ar[7]) | (~ax[7] & ay[7] & ar[7])
                       : (ax[7] & ay[7] & ~ar[7]) | (~ax[7] & ~ay[7] & ar[7]);
  // Subtract and compare with carry keep zero only if it was already set
  assign ar_z = (ar == alu_pkg::BYTE_ZERO) &&
                (!chain_z || sreg[alu_pkg::FLAG_Z]);

  // Logic unit: and, or, xor over the chosen operand
  assign lr = is_or ? (c_rd | ay) : is_xor ? (c_rd ^ ay) : (c_rd & ay);

  // Word adder on a register pair with a six-bit constant
  assign wsum = is_sub ? {1'b0, c_pair} - {11'h000, c_imm[5:0]} :
                         {1'b0, c_pair} + {11'h000, c_imm[5:0]};
  assign wr = wsum[15:0];
  assign wc = wsum[16];
  assign wv = is_sub ? (c_pair[15] & ~wr[15]) : (~c_pair[15] & wr[15]);

  // Multiplier sign and fraction selection
  assign mul_as = c_op inside {alu_pkg::op_multiply_signed,
    alu_pkg::op_multiply_signed_unsigned, alu_pkg::op_fractional_multiply_signed,
    alu_pkg::op_fractional_multiply_mixed};
  assign mul_bs = c_op inside {alu_pkg::op_multiply_signed,
    alu_pkg::op_fractional_multiply_signed};
  assign mul_fr = c_op inside {alu_pkg::op_fractional_multiply,
    alu_pkg::op_fractional_multiply_signed,
    alu_pkg::op_fractional_multiply_mixed};

  mul_unit u_mul (
    .mcand         (c_rd),
    .mplier        (c_rr),
    .mcand_signed  (mul_as),
    .mplier_signed (mul_bs),
    .frac          (mul_fr),
    .product       (mprod),
    .carry         (mc)
  );

  // Flag vectors per class, laid out I T H S V N Z C
  assign mul_zero = {7'h00, (mprod == 16'h0000)};
  assign f_arith  = {2'h2, ar_h, 1'b0, ar_v, ar[7], ar_z, ar_c};
  assign f_logic  = {4'h8, 1'b0, lr[7], (lr == alu_pkg::BYTE_ZERO), 1'b0};
  assign f_compl  = {4'h8, 1'b0, ~c_rd[7], (c_rd == alu_pkg::BYTE_ONES), 1'b1};
  assign f_word   = {3'h4, wr[15] ^ wv, wv, wr[15], (wr == 16'h0000), wc};
  assign f_mul    = {6'h20, mul_zero[0], mc};
  assign rel_tgt  = c_pc + {{4{c_off[11]}}, c_off} + alu_pkg::PC_STEP_1;

  // Per-instruction write-back, flow and flag selection
  always_comb
  begin
    next_rd_we     = 1'b0;
    next_rd_data   = ar;
    next_pair_we   = 1'b0;
    next_prod_we   = 1'b0;
    next_pc_load   = 1'b0;
    next_pc_value  = rel_tgt;
    next_push_we   = 1'b0;
    next_push_data = c_pc + alu_pkg::PC_STEP_1;
    mask           = alu_pkg::MASK_NONE;
    fv             = f_arith;
    cyc            = alu_pkg::CYC_SIMPLE;
    case (c_op)
      alu_pkg::op_add, alu_pkg::op_add_carry, alu_pkg::op_sub_reg,
      alu_pkg::op_sub_imm, alu_pkg::op_sub_reg_carry,
      alu_pkg::op_sub_imm_carry, alu_pkg::op_twos_complement:
      begin
        next_rd_we = 1'b1;
        mask       = alu_pkg::MASK_ARITH;
      end
      alu_pkg::op_compare, alu_pkg::op_compare_with_carry,
      alu_pkg::op_compare_immediate:
        mask = alu_pkg::MASK_ARITH;
      alu_pkg::op_increment, alu_pkg::op_decrement:
      begin
        next_rd_we = 1'b1;
        mask       = alu_pkg::MASK_LOGIC;
      end
      alu_pkg::op_ones_complement:
      begin
        next_rd_we   = 1'b1;
        next_rd_data = alu_pkg::BYTE_ONES - c_rd;
        mask         = alu_pkg::MASK_COMPL;
        fv           = f_compl;
      end
      alu_pkg::op_fill_register_ones:
      begin
        next_rd_we   = 1'b1;
        next_rd_data = alu_pkg::BYTE_ONES;
      end
      alu_pkg::op_and_reg, alu_pkg::op_and_imm, alu_pkg::op_or_reg,
      alu_pkg::op_or_imm, alu_pkg::op_xor_reg, alu_pkg::op_set_bits_mask,
      alu_pkg::op_clear_bits_mask, alu_pkg::op_test_zero_minus,
      alu_pkg::op_zero_register:
      begin
        next_rd_we   = 1'b1;
        next_rd_data = lr;
        mask         = alu_pkg::MASK_LOGIC;
        fv           = f_logic;
      end
      alu_pkg::op_add_imm_word, alu_pkg::op_sub_imm_word:
      begin
        next_pair_we = 1'b1;
        mask         = alu_pkg::MASK_WORD;
        fv           = f_word;
        cyc          = alu_pkg::CYC_WORD;
      end
      alu_pkg::op_multiply_unsigned, alu_pkg::op_multiply_signed,
      alu_pkg::op_multiply_signed_unsigned, alu_pkg::op_fractional_multiply,
      alu_pkg::op_fractional_multiply_signed,
      alu_pkg::op_fractional_multiply_mixed:
      begin
        next_prod_we = 1'b1;
        mask         = alu_pkg::MASK_MUL;
        fv           = f_mul;
        cyc          = alu_pkg::CYC_MUL;
      end
      alu_pkg::op_absolute_jump, alu_pkg::op_absolute_call:
        if (c_large)
        begin
          next_pc_load   = 1'b1;
          next_pc_value  = c_abs;
          next_push_we   = (c_op == alu_pkg::op_absolute_call);
          next_push_data = c_pc + alu_pkg::PC_STEP_2;
          cyc            = next_push_we ? alu_pkg::CYC_CALL_ABS
                                        : alu_pkg::CYC_JUMP_ABS;
        end
      alu_pkg::op_relative_jump:
      begin
        next_pc_load = 1'b1;
        cyc          = alu_pkg::CYC_JUMP_REL;
      end
      alu_pkg::op_relative_call:
      begin
        next_pc_load = 1'b1;
        next_push_we = 1'b1;
        cyc          = alu_pkg::CYC_CALL_REL;
      end
      alu_pkg::op_indirect_jump:
      begin
        next_pc_load  = 1'b1;
        next_pc_value = c_z;
        cyc           = alu_pkg::CYC_JUMP_IND;
      end
      alu_pkg::op_indirect_call:
      begin
        next_pc_load  = 1'b1;
        next_pc_value = c_z;
        next_push_we  = 1'b1;
        cyc           = alu_pkg::CYC_CALL_IND;
      end
      alu_pkg::op_return, alu_pkg::op_interrupt_return:
      begin
        next_pc_load  = 1'b1;
        next_pc_value = c_pop;
        cyc           = alu_pkg::CYC_RETURN;
        if (c_op == alu_pkg::op_interrupt_return)
          mask = alu_pkg::MASK_IRQ;
      end
      alu_pkg::op_compare_skip_equal:
        if (c_rd == c_rr)
        begin
          next_pc_load  = 1'b1;
          next_pc_value = c_pc + (c_long ? alu_pkg::PC_STEP_3
                                         : alu_pkg::PC_STEP_2);
          cyc           = c_long ? alu_pkg::CYC_SKIP_LONG
                                 : alu_pkg::CYC_SKIP_SHORT;
        end
      default:
        mask = alu_pkg::MASK_NONE;
    endcase
  end

  // Only the masked status bits take new values
  assign next_sreg = (sreg & ~mask) | (fv & mask);
  assign fire = (accept && cyc == alu_pkg::CYC_SIMPLE) ||
                (busy && remain == 3'h1);

  // Sequencer: single-cycle ops finish at issue, others count down
  always_ff @(posedge clock)
    if (!rst_n)
    begin
      state  <= alu_pkg::st_idle;
      ready  <= 1'b1;
      remain <= 3'h0;
    end
    else if (accept && cyc != alu_pkg::CYC_SIMPLE)
    begin
      state  <= alu_pkg::st_busy;
      ready  <= 1'b0;
      remain <= cyc - 3'h1;
    end
    else if (busy)
    begin
      remain <= remain - 3'h1;
      if (remain == 3'h1)
      begin
        state <= alu_pkg::st_idle;
        ready <= 1'b1;
      end
    end

  // Capture operands at issue
  always_ff @(posedge clock)
    if (accept)
    begin
      h_op    <= op_code;
      {h_rd, h_rr, h_imm, h_off} <= {rd_in, rr_in, imm, offset};
      {h_pair, h_pc, h_z}        <= {pair_in, pc_in, z_in};
      {h_abs, h_pop}             <= {abs_addr, pop_data};
      {h_long, h_large}          <= {skip_long, large_memory};
    end

  // Completion strobes; data holds between completions
  always_ff @(posedge clock)
    if (!rst_n)
    begin
      {done, rd_we, pair_we, prod_we, pc_load, push_we} <= 6'h00;
      {rd_data, sreg} <= {alu_pkg::BYTE_ZERO, alu_pkg::SREG_RESET};
      {pair_data, prod_data, pc_value, push_data} <= 64'h0;
    end
    else
    begin
      done    <= fire;
      rd_we   <= fire && next_rd_we;
      pair_we <= fire && next_pair_we;
      prod_we <= fire && next_prod_we;
      pc_load <= fire && next_pc_load;
      push_we <= fire && next_push_we;
      if (fire)
      begin
        {rd_data, sreg} <= {next_rd_data, next_sreg};
        {pair_data, prod_data} <= {wr, mprod};
        {pc_value, push_data}  <= {next_pc_value, next_push_data};
      end
    end

  // Checks of completion timing and results
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_idle_then_done;
    !done ##1 done;
  endsequence

  property p_add_reg;
    accept && op_code == alu_pkg::op_add
      |=> done && rd_we && rd_data == $past(rd_in) + $past(rr_in);
  endproperty
  a_add_reg: assert property (p_add_reg) else $error("add result");

  property p_word_add;
    accept && op_code == alu_pkg::op_add_imm_word |=> s_idle_then_done
      ##0 (pair_we && sreg[alu_pkg::FLAG_S] ==
           (sreg[alu_pkg::FLAG_N] ^ sreg[alu_pkg::FLAG_V]));
  endproperty
  a_word_add: assert property (p_word_add) else $error("word add");

  property p_sub_imm;
    accept && op_code == alu_pkg::op_sub_imm
      |=> rd_we && rd_data == $past(rd_in) - $past(imm);
  endproperty
  a_sub_imm: assert property (p_sub_imm) else $error("sub imm");

  property p_sub_carry;
    accept && op_code == alu_pkg::op_sub_reg_carry &&
    sreg[alu_pkg::FLAG_C] && rd_in == rr_in
      |=> rd_data == alu_pkg::BYTE_ONES && sreg[alu_pkg::FLAG_C];
  endproperty
  a_sub_carry: assert property (p_sub_carry) else $error("sbc");

  property p_word_sub;
    accept && op_code == alu_pkg::op_sub_imm_word |=> !pair_we ##1 pair_we;
  endproperty
  a_word_sub: assert property (p_word_sub) else $error("word sub");

  property p_logic_v;
    accept && op_code == alu_pkg::op_xor_reg |=> !sreg[alu_pkg::FLAG_V];
  endproperty
  a_logic_v: assert property (p_logic_v) else $error("logic V");

  property p_clear_bits;
    accept && op_code == alu_pkg::op_clear_bits_mask
      |=> rd_data == ($past(rd_in) & ~$past(imm));
  endproperty
  a_clear_bits: assert property (p_clear_bits) else $error("clr bits");

  property p_zero_reg;
    accept && op_code == alu_pkg::op_zero_register
      |=> rd_data == alu_pkg::BYTE_ZERO && sreg[alu_pkg::FLAG_Z];
  endproperty
  a_zero_reg: assert property (p_zero_reg) else $error("zero reg");

  property p_mul;
    accept && op_code == alu_pkg::op_multiply_unsigned |=> !prod_we ##1
      (prod_we && sreg[alu_pkg::FLAG_Z] == (prod_data == 16'h0000));
  endproperty
  a_mul: assert property (p_mul) else $error("multiply");

  property p_rel_call;
    accept && op_code == alu_pkg::op_relative_call
      |=> !done ##1 s_idle_then_done ##0 (pc_load && push_we);
  endproperty
  a_rel_call: assert property (p_rel_call) else $error("rel call");

  property p_ind_jump;
    accept && op_code == alu_pkg::op_indirect_jump
      |=> !pc_load ##1 (pc_load && pc_value == $past(z_in, 2));
  endproperty
  a_ind_jump: assert property (p_ind_jump) else $error("ind jump");

  property p_irq_return;
    accept && op_code == alu_pkg::op_interrupt_return
      |-> ##4 (done && pc_load && sreg[alu_pkg::FLAG_I]);
  endproperty
  a_irq_return: assert property (p_irq_return) else $error("interrupt_return");

endmodule

`default_nettype wire

// >>> alu_pkg.sv
// Purpose: Shared constants and types for the execution datapath.
// Assumes: One core clock; status register laid out as I T H S V N Z C.
// Notes:   Cycle counts are whole core clocks from issue to completion.
`default_nettype none

package alu_pkg;

  // Status register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  localparam logic [7:0] SREG_RESET = 8'h00;

  // Which status bits each instruction class may change
  localparam logic [7:0] MASK_ARITH = 8'h2f;
  localparam logic [7:0] MASK_LOGIC = 8'h0e;
  localparam logic [7:0] MASK_COMPL = 8'h0f;
  localparam logic [7:0] MASK_WORD  = 8'h1f;
  localparam logic [7:0] MASK_MUL   = 8'h03;
  localparam logic [7:0] MASK_IRQ   = 8'h80;
  localparam logic [7:0] MASK_NONE  = 8'h00;

  // Fixed operand values
  localparam logic [7:0]  BYTE_ONES = 8'hff;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  localparam logic [7:0]  BYTE_ONE  = 8'h01;
  localparam logic [15:0] PC_STEP_1 = 16'h0001;
  localparam logic [15:0] PC_STEP_2 = 16'h0002;
  localparam logic [15:0] PC_STEP_3 = 16'h0003;

  // Clocks per instruction
  localparam logic [2:0] CYC_SIMPLE     = 3'h1;
  localparam logic [2:0] CYC_WORD       = 3'h2;
  localparam logic [2:0] CYC_MUL        = 3'h2;
  localparam logic [2:0] CYC_JUMP_REL   = 3'h2;
  localparam logic [2:0] CYC_JUMP_IND   = 3'h2;
  localparam logic [2:0] CYC_CALL_REL   = 3'h3;
  localparam logic [2:0] CYC_CALL_IND   = 3'h3;
  localparam logic [2:0] CYC_RETURN     = 3'h4;
  localparam logic [2:0] CYC_JUMP_ABS   = 3'h3;
  localparam logic [2:0] CYC_CALL_ABS   = 3'h4;
  localparam logic [2:0] CYC_SKIP_SHORT = 3'h2;
  localparam logic [2:0] CYC_SKIP_LONG  = 3'h3;

  // Instruction codes presented by the decoder
  typedef enum logic [5:0] {
    op_add, op_add_carry, op_add_imm_word,
    op_sub_reg, op_sub_imm, op_sub_reg_carry, op_sub_imm_carry,
    op_sub_imm_word,
    op_and_reg, op_and_imm, op_or_reg, op_or_imm, op_xor_reg,
    op_ones_complement, op_twos_complement,
    op_set_bits_mask, op_clear_bits_mask,
    op_increment, op_decrement,
    op_test_zero_minus, op_zero_register, op_fill_register_ones,
    op_multiply_unsigned, op_multiply_signed,
    op_multiply_signed_unsigned,
    op_fractional_multiply, op_fractional_multiply_signed,
    op_fractional_multiply_mixed,
    op_absolute_jump, op_absolute_call,
    op_relative_jump, op_indirect_jump,
    op_relative_call, op_indirect_call,
    op_return, op_interrupt_return,
    op_compare_skip_equal, op_compare,
    op_compare_with_carry, op_compare_immediate
  } op_t;

  // Sequencer states
  typedef enum logic [1:0] {
    st_idle = 2'h1,
    st_busy = 2'h2
  } state_t;

endpackage

`default_nettype wire

// >>> mul_unit.sv
// Purpose: 8 by 8 multiplier with per-operand sign and fractional shift.
// Assumes: Purely combinational; the caller registers the result.
// Notes:   Carry is taken from bit 15 before the fractional shift.
`default_nettype none

module mul_unit (
  // Operands
  input  wire logic [7:0]  mcand,
  input  wire logic [7:0]  mplier,
  // Mode
  input  wire logic        mcand_signed,
  input  wire logic        mplier_signed,
  input  wire logic        frac,
  // Result
  output logic      [15:0] product,
  output logic             carry
);

  logic signed [8:0]  ext_a;
  logic signed [8:0]  ext_b;
  logic signed [17:0] full;
  logic        [15:0] raw;

  // Sign-extend each operand only when it is treated as signed
  assign ext_a   = {mcand_signed & mcand[7], mcand};
  assign ext_b   = {mplier_signed & mplier[7], mplier};
  assign full    = ext_a * ext_b;
  assign raw     = full[15:0];
  assign carry   = raw[15];
  // Fractional forms move the binary point by one place
  assign product = frac ? {raw[14:0], 1'b0} : raw;

endmodule

`default_nettype wire

// >>> core_regs_model.sv
// Purpose: Program counter and return stack beside the datapath.
// Assumes: Loads and pushes arrive as one-cycle pulses.
// Notes:   Stack is one deep; enough for a single call.
`default_nettype none

module core_regs_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Writes from the datapath
  input  wire logic        pc_load,
  input  wire logic [15:0] pc_value,
  input  wire logic        push_we,
  input  wire logic [15:0] push_data,
  // State seen by the datapath
  output logic      [15:0] pc,
  output logic      [15:0] stack_top
);
  timeunit 1ns;
  timeprecision 1ps;
  // Program counter follows loads, stack keeps the last push
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      pc        <= 16'h0100;
      stack_top <= 16'h0000;
    end
    else
    begin
      if (pc_load) pc <= pc_value;
      if (push_we) stack_top <= push_data;
    end
  end
endmodule

`default_nettype wire

// >>> cpu_alu_and_branch_exec_test.sv
// Purpose: Self-checking bench for the execution datapath.
// Assumes: Sreg starts at zero and carries over between rows.
// Notes:   Inputs change at the falling edge only.
`default_nettype none

module cpu_alu_and_branch_exec_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    alu_pkg::op_t op;
    logic [15:0]  a;
    logic [7:0]   b;
    logic [2:0]   we;
    logic [15:0]  v;
    logic [7:0]   f;
    int           n;
  } row_t;
  // Operand a, operand b, writes {rd,pair,prod}, value, flags, cycles
  row_t rows [19] = '{
    '{alu_pkg::op_add, 16'h000f, 8'h01, 3'h4, 16'h0010, 8'h20, 1},
    '{alu_pkg::op_sub_reg, 16'h0000, 8'h01, 3'h4, 16'h00ff, 8'h25, 1},
    '{alu_pkg::op_add_carry, 16'h0001, 8'h01, 3'h4, 16'h0003, 8'h00, 1},
    '{alu_pkg::op_and_imm, 16'h00f0, 8'h80, 3'h4, 16'h0080, 8'h04, 1},
    '{alu_pkg::op_clear_bits_mask, 16'h00ff, 8'h0f, 3'h4, 16'h00f0,
      8'h04, 1},
    '{alu_pkg::op_set_bits_mask, 16'h0000, 8'h00, 3'h4, 16'h0000,
      8'h02, 1},
    '{alu_pkg::op_zero_register, 16'h005a, 8'h5a, 3'h4, 16'h0000,
      8'h02, 1},
    '{alu_pkg::op_multiply_unsigned, 16'h00ff, 8'hff, 3'h1, 16'hfe01,
      8'h01, 2},
    '{alu_pkg::op_fractional_multiply, 16'h0080, 8'h80, 3'h1, 16'h8000,
      8'h00, 2},
    '{alu_pkg::op_multiply_signed, 16'h00ff, 8'h01, 3'h1, 16'hffff,
      8'h01, 2},
    '{alu_pkg::op_compare_immediate, 16'h0010, 8'h10, 3'h0, 16'h0000,
      8'h02, 1},
    '{alu_pkg::op_add_imm_word, 16'hffff, 8'h01, 3'h2, 16'h0000,
      8'h03, 2},
    '{alu_pkg::op_sub_imm_word, 16'h8000, 8'h01, 3'h2, 16'h7fff,
      8'h18, 2},
    '{alu_pkg::op_sub_imm_carry, 16'h0000, 8'h00, 3'h4, 16'h0000,
      8'h10, 1},
    '{alu_pkg::op_add, 16'h007f, 8'h01, 3'h4, 16'h0080, 8'h3c, 1},
    '{alu_pkg::op_xor_reg, 16'h00f0, 8'h0f, 3'h4, 16'h00ff, 8'h34, 1},
    '{alu_pkg::op_twos_complement, 16'h0001, 8'h00, 3'h4, 16'h00ff,
      8'h35, 1},
    '{alu_pkg::op_sub_reg_carry, 16'h0033, 8'h33, 3'h4, 16'h00ff,
      8'h35, 1},
    '{alu_pkg::op_absolute_jump, 16'h0000, 8'h00, 3'h0, 16'h0000,
      8'h35, 1}};
  logic clock, rst_n, op_valid, skip_long, ready, done, rd_we, pair_we;
  logic prod_we, pc_load, push_we;
  logic [7:0] b, rd_data, sreg;
  logic [15:0] a, pc, stack_top, pair_data, prod_data, pc_value, push_data;
  alu_pkg::op_t op_code;
  int miscompares = 0;
  int num_checks = 0;

  alu_branch_exec alu_branch_exec_i (.clock(clock), .rst_n(rst_n),
    .op_valid(op_valid), .op_code(op_code), .large_memory(1'b0),
    .skip_long(skip_long), .rd_in(a[7:0]), .rr_in(b), .imm(b),
    .pair_in(a), .pc_in(pc), .offset(a[11:0]), .z_in(a),
    .abs_addr(16'h0000), .pop_data(stack_top), .ready(ready), .done(done),
    .rd_we(rd_we), .rd_data(rd_data), .pair_we(pair_we),
    .pair_data(pair_data), .prod_we(prod_we), .prod_data(prod_data),
    .pc_load(pc_load), .pc_value(pc_value), .push_we(push_we),
    .push_data(push_data), .sreg(sreg));
  core_regs_model core_regs_model_i (.clock(clock), .rst_n(rst_n),
    .pc_load(pc_load), .pc_value(pc_value), .push_we(push_we),
    .push_data(push_data), .pc(pc), .stack_top(stack_top));

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      miscompares++;
    end
  endtask

  task automatic results;
    if (miscompares == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Issue one request, then count cycles up to done
  task automatic run(input alu_pkg::op_t o, input logic [15:0] x,
                     input logic [7:0] y, input int n);
    int cnt;
    op_code = o;
    a = x;
    b = y;
    op_valid = 1'b1;
    @(negedge clock);
    op_valid = 1'b0;
    cnt = 1;
    check("ready", {15'h0, ready}, {15'h0, n == 1});
    while (done !== 1'b1 && cnt < 8)
    begin
      @(negedge clock);
      cnt++;
    end
    check("cycles", cnt[15:0], n[15:0]);
  endtask

  // Core clock, 5 ns period
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Watchdog well beyond the expected run
  initial
  begin
    #10000;
    miscompares++;
    results();
  end

  initial
  begin
    rst_n = 1'b0;
    op_valid = 1'b0;
    op_code = alu_pkg::op_add;
    skip_long = 1'b0;
    a = 16'h0000;
    b = 8'h00;
    repeat (12) @(negedge clock);
    check("reset ready", {15'h0, ready}, 16'h0001);
    check("reset sreg", {8'h00, sreg}, 16'h0000);
    rst_n = 1'b1;
    @(negedge clock);
    foreach (rows[i])
    begin
      run(rows[i].op, rows[i].a, rows[i].b, rows[i].n);
      check("writes", {13'h0, rd_we, pair_we, prod_we},
            {13'h0, rows[i].we});
      if (rows[i].we != 3'h0)
        check("data", rd_we ? {8'h00, rd_data} : prod_we ? prod_data
              : pair_data, rows[i].v);
      check("sreg", {8'h00, sreg}, {8'h00, rows[i].f});
    end
    // Flow changes; the model applies each pulse one edge later
    run(alu_pkg::op_indirect_call, 16'h1234, 8'h00, 3);
    check("call target", pc_value, 16'h1234);
    @(negedge clock);
    check("return addr", stack_top, 16'h0101);
    skip_long = 1'b1;
    run(alu_pkg::op_compare_skip_equal, 16'h0033, 8'h33, 3);
    check("skip target", pc_value, 16'h1237);
    @(negedge clock);
    // Offset 0xffe steps back by one
    run(alu_pkg::op_relative_jump, 16'h0ffe, 8'h00, 2);
    @(negedge clock);
    check("jump pc", pc, 16'h1236);
    run(alu_pkg::op_relative_call, 16'h0010, 8'h00, 3);
    check("relative_call target", pc_value, 16'h1247);
    @(negedge clock);
    check("relative_call return", stack_top, 16'h1237);
    run(alu_pkg::op_indirect_jump, 16'h2000, 8'h00, 2);
    check("indirect_jump target", pc_value, 16'h2000);
    check("flags kept", {8'h00, sreg}, 16'h0035);
    run(alu_pkg::op_interrupt_return, 16'h0000, 8'h00, 4);
    check("interrupt_return target", pc_value, 16'h1237);
    check("interrupt_return flags", {8'h00, sreg}, 16'h00b5);
    results();
  end
endmodule

`default_nettype wire
